//--- pcb_pkg.sv
package pcb_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  PCB_IDX_PCS_CONFIG_STATUS   = 8'h16;
  localparam logic [7:0]  PCB_IDX_REDUCED_IFACE_CTRL  = 8'h17;
  localparam logic [7:0]  PCB_IDX_CTRL_STATUS         = 8'h18;
  localparam logic [9:0]  PCB_ADDR_PCS_CONFIG_STATUS  = {PCB_IDX_PCS_CONFIG_STATUS, 2'h0};
  localparam logic [9:0]  PCB_ADDR_REDUCED_IFACE_CTRL = {PCB_IDX_REDUCED_IFACE_CTRL, 2'h0};
  localparam logic [9:0]  PCB_ADDR_CTRL_STATUS        = {PCB_IDX_CTRL_STATUS, 2'h0};

  // coding sublayer register fields
  localparam int PCB_PCS_FIBER_BIT       = 6;
  localparam int PCB_PCS_FORCE_BIT       = 5;
  localparam int PCB_PCS_RSVD_BIT        = 4;
  localparam int PCB_PCS_FAR_FAULT_BIT   = 3;
  localparam int PCB_PCS_NRZI_BIT        = 2;
  localparam int PCB_PCS_TX_WHITEN_BIT   = 1;
  localparam int PCB_PCS_RX_WHITEN_BIT   = 0;

  // reduced interface register fields
  localparam int PCB_RIF_RSVD_HI_BIT     = 15;
  localparam int PCB_RIF_MASTER_BIT      = 14;
  localparam int PCB_RIF_ALIGN_DIS_BIT   = 13;
  localparam int PCB_RIF_RSVD_LO_MSB     = 12;
  localparam int PCB_RIF_RSVD_LO_LSB     = 9;

  // control/status register fields
  localparam int PCB_CS_SOFT_RESET_BIT   = 0;
  localparam int PCB_CS_LINK_GOOD_BIT    = 1;
  localparam int PCB_CS_RECONF_PEND_BIT  = 2;

  localparam logic [15:0] PCB_RESET_VALUE        = 16'h0000;
  localparam logic [31:0] PCB_RDATA_UNMAPPED     = 32'h0000_0000;
  // realigner: symbol of 4 bits at 2 bits per reference edge
  localparam logic [1:0]  PCB_SYMBOL_EDGES       = 2'h2;
  localparam int          PCB_SYNC_STAGES        = 2;

  typedef struct packed {
    logic fiber_mode_enable;
    logic link_force;
    logic far_fault_indicate_enable;
    logic nrzi_skip;
    logic tx_whitening_skip;
    logic rx_whitening_skip;
    logic clock_master;
    logic tx_phase_align_disable;
  } pcb_cfg_t;

  typedef struct packed {
    logic fiber;
    logic clock_master;
  } pcb_strap_t;

endpackage

//--- pcb_sync.sv
`timescale 1ns/1ps
module pcb_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // pcb_sync

//--- pcb_tx_align.sv
`timescale 1ns/1ps
module pcb_tx_align
  import pcb_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic align_disable,
  input  wire logic tx_enable,
  // outputs
  output logic      phase_q,
  output logic      realign_pulse
);
  logic       tx_en_prev_q;
  logic [1:0] edge_cnt_q;
  logic       sof;

  assign sof           = tx_enable && !tx_en_prev_q;
  assign realign_pulse = sof && !align_disable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_prev_q <= 1'b0;
    end else begin
      tx_en_prev_q <= tx_enable;
    end
  end

  // realigned: restart phase at packet start; otherwise free-run in whole symbols
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_q <= 2'h0;
    end else if (realign_pulse) begin
      edge_cnt_q <= 2'h1;
    end else if (edge_cnt_q == PCB_SYMBOL_EDGES - 2'h1) begin
      edge_cnt_q <= 2'h0;
    end else begin
      edge_cnt_q <= edge_cnt_q + 2'h1;
    end
  end

  assign phase_q = (edge_cnt_q == 2'h0);
endmodule // pcb_tx_align

//--- pcb_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - force bit OR input forces good link
// - bit 4 ignores writes, reads zero
// - far fault enable, default from fiber strap
// - nrzi skip bit, resets to zero
// - tx whitening skip, default from fiber strap
// - rx whitening skip, default from fiber strap
// - clock master bit selects reference clock mode
// - align disable clear realigns each packet start
// - align disable set sends whole symbols
// - fiber change needs soft reset to apply
module pcb_regs
  import pcb_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // strap pins
  input  wire logic        strap_fiber,
  input  wire logic        strap_clock_master,
  // datapath
  input  wire logic        mac_link_force_input,
  input  wire logic        link_ok_raw,
  input  wire logic        tx_enable,
  // controls to datapath
  output pcb_cfg_t         cfg_q,
  output logic             link_good,
  output logic             tx_phase_q,
  output logic             tx_realign_pulse
);
  pcb_strap_t  strap_raw;
  pcb_strap_t  strap_s;
  logic        force_s;
  logic        link_raw_s;
  logic [1:0]  load_pend_q;
  logic        cfg_applied_q;
  logic [15:0] pcs_q;
  logic [15:0] rif_q;
  logic        fiber_applied_q;
  logic        reconf_pend_q;
  logic        wr_en;
  logic        rd_en;
  logic        hit_pcs;
  logic        hit_rif;
  logic        hit_cs;
  logic        soft_reset;
  logic [15:0] wmask;
  logic [15:0] pcs_rd;
  logic [15:0] rif_rd;
  logic [15:0] cs_rd;

  assign strap_raw = '{fiber: strap_fiber, clock_master: strap_clock_master};

  pcb_sync #(.WIDTH(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({strap_raw, mac_link_force_input, link_ok_raw}),
    .sync_o  ({strap_s, force_s, link_raw_s})
  );

  // apb decode, zero wait states
  assign hit_pcs    = (paddr == PCB_ADDR_PCS_CONFIG_STATUS);
  assign hit_rif    = (paddr == PCB_ADDR_REDUCED_IFACE_CTRL);
  assign hit_cs     = (paddr == PCB_ADDR_CTRL_STATUS);
  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && !pwrite;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !(hit_pcs || hit_rif || hit_cs);
  assign wmask      = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign soft_reset = wr_en && hit_cs && pstrb[0] && pwdata[PCB_CS_SOFT_RESET_BIT];

  // strap capture waits out both synchroniser stages, which reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pend_q   <= 2'h3;
      cfg_applied_q <= 1'b0;
    end else begin
      load_pend_q   <= {load_pend_q[0], 1'b0};
      cfg_applied_q <= (load_pend_q == 2'h0);
    end
  end

  // coding sublayer register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcs_q <= PCB_RESET_VALUE;
    end else if (!cfg_applied_q) begin
      pcs_q[PCB_PCS_FIBER_BIT]     <= strap_s.fiber;
      pcs_q[PCB_PCS_FAR_FAULT_BIT] <= strap_s.fiber;
      pcs_q[PCB_PCS_TX_WHITEN_BIT] <= strap_s.fiber;
      pcs_q[PCB_PCS_RX_WHITEN_BIT] <= strap_s.fiber;
    end else if (wr_en && hit_pcs) begin
      pcs_q <= (pcs_q & ~wmask) | (pwdata[15:0] & wmask);
      pcs_q[PCB_PCS_RSVD_BIT] <= 1'b0;
    end
  end

  // reduced interface register; reserved bits stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif_q <= PCB_RESET_VALUE;
    end else if (!cfg_applied_q) begin
      rif_q[PCB_RIF_MASTER_BIT] <= strap_s.clock_master;
    end else if (wr_en && hit_rif) begin
      rif_q <= (rif_q & ~wmask) | (pwdata[15:0] & wmask);
    end
  end

  // fiber mode only takes effect on soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fiber_applied_q <= 1'b0;
    end else if (!cfg_applied_q || soft_reset) begin
      fiber_applied_q <= !cfg_applied_q ? strap_s.fiber : pcs_q[PCB_PCS_FIBER_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reconf_pend_q <= 1'b0;
    end else begin
      reconf_pend_q <= pcs_q[PCB_PCS_FIBER_BIT] != fiber_applied_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q.fiber_mode_enable         <= fiber_applied_q;
      cfg_q.link_force                <= pcs_q[PCB_PCS_FORCE_BIT] | force_s;
      cfg_q.far_fault_indicate_enable <= pcs_q[PCB_PCS_FAR_FAULT_BIT];
      cfg_q.nrzi_skip                 <= pcs_q[PCB_PCS_NRZI_BIT];
      cfg_q.tx_whitening_skip         <= pcs_q[PCB_PCS_TX_WHITEN_BIT];
      cfg_q.rx_whitening_skip         <= pcs_q[PCB_PCS_RX_WHITEN_BIT];
      cfg_q.clock_master              <= rif_q[PCB_RIF_MASTER_BIT];
      cfg_q.tx_phase_align_disable    <= rif_q[PCB_RIF_ALIGN_DIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_good <= 1'b0;
    end else begin
      link_good <= cfg_q.link_force | link_raw_s;
    end
  end

  pcb_tx_align u_align (
    .pclk          (pclk),
    .presetn       (presetn),
    .align_disable (cfg_q.tx_phase_align_disable),
    .tx_enable     (tx_enable),
    .phase_q       (tx_phase_q),
    .realign_pulse (tx_realign_pulse)
  );

  // read mux
  always_comb begin
    pcs_rd = pcs_q;
    pcs_rd[PCB_PCS_RSVD_BIT] = 1'b0;
    rif_rd = rif_q;
    cs_rd  = 16'h0000;
    cs_rd[PCB_CS_LINK_GOOD_BIT]   = link_good;
    cs_rd[PCB_CS_RECONF_PEND_BIT] = reconf_pend_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PCB_RDATA_UNMAPPED;
    end else if (rd_en && !penable) begin
      if (hit_pcs) begin
        prdata <= {16'h0000, pcs_rd};
      end else if (hit_rif) begin
        prdata <= {16'h0000, rif_rd};
      end else if (hit_cs) begin
        prdata <= {16'h0000, cs_rd};
      end else begin
        prdata <= PCB_RDATA_UNMAPPED;
      end
    end
  end
endmodule // pcb_regs

//--- pcb_mac_model.sv
`timescale 1ns/1ps
module pcb_mac_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench requests
  input  wire logic send,
  input  wire logic force_req,
  // mac side
  output logic      tx_enable,
  output logic      mac_link_force_input
);
  logic [2:0] len_q;

  // one frame of six cycles per request, never overlapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) len_q <= 3'h0;
    else if (send && len_q == 3'h0) len_q <= 3'h6;
    else if (len_q != 3'h0) len_q <= len_q - 3'h1;
  end
  assign tx_enable = (len_q != 3'h0);
  assign mac_link_force_input = force_req;
endmodule // pcb_mac_model

//--- pcb_regs_chk.sv
`timescale 1ns/1ps
module pcb_regs_chk
  import pcb_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // straps and datapath
  input wire logic        strap_fiber,
  input wire logic        strap_clock_master,
  input wire logic        mac_link_force_input,
  input wire logic        link_ok_raw,
  input wire logic        tx_enable,
  input wire pcb_cfg_t    cfg_q,
  input wire logic        link_good,
  input wire logic        tx_phase_q,
  input wire logic        tx_realign_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel & penable;
  wire wr_pcs = acc & pwrite & pstrb[0] & (paddr == PCB_ADDR_PCS_CONFIG_STATUS);
  wire wr_rif = acc & pwrite & pstrb[1] & (paddr == PCB_ADDR_REDUCED_IFACE_CTRL);
  wire rd_pcs = acc & !pwrite & (paddr == PCB_ADDR_PCS_CONFIG_STATUS);
  property p_force; cfg_q.link_force |-> ##[0:2] link_good; endproperty
  a_force: assert property (p_force) else $error("link not forced");
  property p_macf; mac_link_force_input [*5] |-> link_good; endproperty
  a_macf: assert property (p_macf) else $error("input force ignored");
  property p_rsvd; rd_pcs |-> prdata[4] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read set");
  property p_pcs;
    wr_pcs |-> ##2 {cfg_q.far_fault_indicate_enable, cfg_q.nrzi_skip, cfg_q.tx_whitening_skip,
                    cfg_q.rx_whitening_skip} == $past(pwdata[3:0], 2);
  endproperty
  a_pcs: assert property (p_pcs) else $error("coding bits not applied");
  property p_rif;
    wr_rif |-> ##2 {cfg_q.clock_master, cfg_q.tx_phase_align_disable} == $past(pwdata[14:13], 2);
  endproperty
  a_rif: assert property (p_rif) else $error("iface bits not applied");
  property p_align; $rose(tx_enable) && !cfg_q.tx_phase_align_disable |-> tx_realign_pulse; endproperty
  a_align: assert property (p_align) else $error("no realign at frame start");
  property p_noalign; cfg_q.tx_phase_align_disable |-> !tx_realign_pulse; endproperty
  a_noalign: assert property (p_noalign) else $error("realign while disabled");
  property p_whole;
    cfg_q.tx_phase_align_disable && $past(cfg_q.tx_phase_align_disable) |-> tx_phase_q != $past(tx_phase_q);
  endproperty
  a_whole: assert property (p_whole) else $error("symbol boundary lost");
  property p_strap;
    $rose(presetn) |-> ##4 {cfg_q.fiber_mode_enable, cfg_q.far_fault_indicate_enable, cfg_q.nrzi_skip,
      cfg_q.tx_whitening_skip, cfg_q.rx_whitening_skip, cfg_q.clock_master}
      == {strap_fiber, strap_fiber, 1'b0, strap_fiber, strap_fiber, strap_clock_master};
  endproperty
  a_strap: assert property (p_strap) else $error("strap defaults wrong");
  cover property (wr_pcs);
  cover property ($rose(tx_enable) && tx_realign_pulse);
  cover property (acc && pslverr);
endmodule // pcb_regs_chk

//--- pcb_regs_tb.sv
`timescale 1ns/1ps
module pcb_regs_tb
  import pcb_pkg::*;
;
  localparam logic [9:0] PA = PCB_ADDR_PCS_CONFIG_STATUS;
  localparam logic [9:0] RA = PCB_ADDR_REDUCED_IFACE_CTRL;
  localparam logic [9:0]  T_A [6] = '{PA, PA, PA, PA, RA, RA};
  localparam logic [31:0] T_W [6] = '{32'h3f, 32'h14, 32'habcd_0001, 32'h0, 32'h2000, 32'h0};
  localparam logic [31:0] T_X [6] = '{32'h2f, 32'h04, 32'h1, 32'h0, 32'h2000, 32'h0};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, err, mac_link_force_input, tx_enable, link_good, tx_phase_q, tx_realign_pulse;
  logic        strap_fiber = 1'b1, strap_clock_master = 1'b1, link_ok_raw = 1'b0, send = 1'b0, force_req = 1'b0;
  pcb_cfg_t    cfg_q;
  int          n_mismatch = 0, checks = 0, cyc = 0, pulses = 0, p0;

  always #20 pclk = ~pclk;
  pcb_regs i_pcb_regs (.*);
  pcb_mac_model i_pcb_mac_model (.*);

  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tx_realign_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      end_sim;
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_reset(input logic f, input logic m);
    presetn <= 1'b0;
    strap_fiber <= f;
    strap_clock_master <= m;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task pkt;
    p0 = pulses;
    @(posedge pclk);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask

  task wait_chk(input string nm, input logic exp);
    repeat (5) @(posedge pclk);
    chk(nm, {31'h0, exp}, {31'h0, link_good});
  endtask

  initial begin
    do_reset(1'b1, 1'b1);
    apb(1'b0, PA, 32'h0);
    chk("pcs reset", 32'h4b, rd);
    apb(1'b0, RA, 32'h0);
    chk("iface reset", 32'h4000, rd);
    $display("test straps done");
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, T_A[i], T_W[i]);
      apb(1'b0, T_A[i], 32'h0);
      chk("row read", T_X[i], rd);
    end
    $display("test rows done");
    apb(1'b0, 10'h03c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    pkt;
    chk("realign on", p0 + 1, pulses);
    apb(1'b1, RA, 32'h2000);
    pkt;
    chk("realign off", p0, pulses);
    $display("test realign done");
    force_req <= 1'b1;
    wait_chk("input force", 1'b1);
    force_req <= 1'b0;
    apb(1'b1, PA, 32'h20);
    wait_chk("bit force", 1'b1);
    apb(1'b1, PA, 32'h0);
    wait_chk("no force", 1'b0);
    $display("test force done");
    apb(1'b1, PA, 32'h40);
    repeat (3) @(posedge pclk);
    chk("fiber held", 32'h0, {31'h0, cfg_q.fiber_mode_enable});
    apb(1'b0, PCB_ADDR_CTRL_STATUS, 32'h0);
    chk("reconf pending", 32'h4, rd);
    apb(1'b1, PCB_ADDR_CTRL_STATUS, 32'h1);
    repeat (4) @(posedge pclk);
    chk("fiber applied", 32'h1, {31'h0, cfg_q.fiber_mode_enable});
    apb(1'b0, PCB_ADDR_CTRL_STATUS, 32'h0);
    chk("reconf done", 32'h0, rd);
    $display("test fiber done");
    end_sim;
  end
endmodule // pcb_regs_tb

bind pcb_regs pcb_regs_chk i_pcb_regs_chk (.*);
